/* logic/osr_pkg.sv */
`default_nettype none
package osr_pkg;

  // Register width and reset contents
  localparam int OSR_WIDTH = 8;
  localparam logic OSR_STAGE_RST = 1'b0;

  // Mode decoded from the control pins
  typedef enum logic [1:0]
  {
    OSR_HOLD = 2'b00,
    OSR_LOAD = 2'b01,
    OSR_SHIFT = 2'b10,
    OSR_SIGN = 2'b11
  } osr_mode_t;

  // Control and serial pins, sampled together
  typedef struct packed
  {
    logic gate_n;
    logic shift_sel;
    logic keep_n;
    logic entry_sel;
    logic entry_a;
    logic entry_b;
    logic out_en_n;
  } osr_pins_t;

  localparam int OSR_PINS_W = $bits(osr_pins_t);
  // Gate and output enable idle high
  localparam logic [OSR_PINS_W-1:0] OSR_PINS_RST = 7'h41;

  // Wishbone register map
  localparam int OSR_ADR_W = 4;
  localparam logic [OSR_ADR_W-1:0] OSR_STATUS_OFS = 4'h0;
  localparam logic [OSR_ADR_W-1:0] OSR_CTRL_OFS = 4'h4;
  localparam logic [OSR_ADR_W-1:0] OSR_COUNT_OFS = 4'h8;

  // Status fields
  localparam int OSR_ST_MODE_LSB = 8;
  localparam int OSR_ST_DRV_BIT = 10;

  // Control fields
  localparam int OSR_CTRL_CLR_BIT = 0;
  localparam int OSR_CTRL_CNT_BIT = 1;
  localparam logic OSR_CNT_EN_RST = 1'b1;

  // Shift edge counter
  localparam int OSR_CNT_W = 16;
  localparam logic [OSR_CNT_W-1:0] OSR_CNT_RST = 16'h0000;
  localparam logic [OSR_CNT_W-1:0] OSR_CNT_ONE = 16'h0001;

endpackage
`default_nettype wire

/* logic/osr_shift_reg.sv */
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module osr_shift_reg #(
  parameter int WIDTH = osr_pkg::OSR_WIDTH
)
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic clear_n_i,
  input wire logic shift_load_gate_n_i,
  input wire logic shift_sel_i,
  input wire logic top_bit_keep_n_i,
  input wire logic entry_sel_i,
  input wire logic entry_bit_a_i,
  input wire logic entry_bit_b_i,
  input wire logic out_en_n_i,
  input wire logic [WIDTH-1:0] par_bus_i,
  output logic [WIDTH-1:0] par_bus_o,
  output logic [WIDTH-1:0] par_bus_oe_o,
  output logic ser_out_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [osr_pkg::OSR_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  logic [1:0] rst_sync;
  logic rst_n;
  logic clr_arst_n;
  logic [1:0] clr_sync;
  logic stage_rst_n;
  logic [osr_pkg::OSR_PINS_W-1:0] pins_raw;
  logic [osr_pkg::OSR_PINS_W-1:0] pins_q;
  osr_pkg::osr_pins_t pins;
  logic [WIDTH-1:0] par_in;
  osr_pkg::osr_mode_t mode;
  logic entry_bit;
  logic [WIDTH-1:0] upper;
  logic [WIDTH-1:0] stages;
  logic drive_en;
  logic soft_clr;
  logic cnt_en;
  logic [osr_pkg::OSR_CNT_W-1:0] shift_cnt;
  logic wb_req;
  logic wr_fire;
  logic [31:0] rd_word;

  // Reset release through two flip-flops
  always_ff @(posedge core_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rst_sync <= 2'b00;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // Clear pin asserts at once, releases on the clock
  assign clr_arst_n = clear_n_i & rst_n;

  always_ff @(posedge core_clk_i or negedge clr_arst_n)
  begin
    if (!clr_arst_n)
    begin
      clr_sync <= 2'b00;
    end
    else
    begin
      clr_sync <= {clr_sync[0], 1'b1};
    end
  end

  assign stage_rst_n = clr_sync[1];

  // Pins are sampled together so modes and data stay aligned
  assign pins_raw = {shift_load_gate_n_i, shift_sel_i, top_bit_keep_n_i,
    entry_sel_i, entry_bit_a_i, entry_bit_b_i, out_en_n_i};

  osr_sync #(
    .W(osr_pkg::OSR_PINS_W),
    .RST_VAL(osr_pkg::OSR_PINS_RST)
  )
  u_pin_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .d_i(pins_raw),
    .q_o(pins_q)
  );

  assign pins = osr_pkg::osr_pins_t'(pins_q);

  osr_sync #(
    .W(WIDTH),
    .RST_VAL('0)
  )
  u_bus_sync (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .d_i(par_bus_i),
    .q_o(par_in)
  );

  // Mode decode; output enable plays no part here
  always_comb
  begin
    case ({pins.gate_n, pins.shift_sel})
      2'b00: mode = osr_pkg::OSR_LOAD;
      2'b01: mode = pins.keep_n ? osr_pkg::OSR_SHIFT : osr_pkg::OSR_SIGN;
      default: mode = osr_pkg::OSR_HOLD;
    endcase
  end

  // Bit entering the top stage
  always_comb
  begin
    if (mode == osr_pkg::OSR_SIGN)
    begin
      entry_bit = stages[WIDTH-1];
    end
    else if (pins.entry_sel)
    begin
      entry_bit = pins.entry_b;
    end
    else
    begin
      entry_bit = pins.entry_a;
    end
  end

  // Each stage sees the pre-edge value of the one above
  assign upper = {entry_bit, stages[WIDTH-1:1]};

  for (genvar i = 0; i < WIDTH; i++)
  begin : g_stage
    osr_stage u_stage (
      .clk_i(core_clk_i),
      .rst_n_i(stage_rst_n),
      .sync_clr_i(soft_clr),
      .mode_i(mode),
      .par_i(par_in[i]),
      .upper_i(upper[i]),
      .q_o(stages[i])
    );
  end

  // Drivers on with shift select high or in clear, with output enable low
  assign drive_en = ~pins.out_en_n
    & (pins.shift_sel | ~stage_rst_n);
  assign par_bus_oe_o = {WIDTH{drive_en}};
  assign par_bus_o = stages;
  assign ser_out_o = stages[0];

  // Wishbone slave, one wait state
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_fire = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= wb_req;
    end
  end

  always_comb
  begin
    rd_word = '0;
    case (wb_adr_i)
      osr_pkg::OSR_STATUS_OFS:
      begin
        rd_word[WIDTH-1:0] = stages;
        rd_word[osr_pkg::OSR_ST_MODE_LSB +: 2] = mode;
        rd_word[osr_pkg::OSR_ST_DRV_BIT] = drive_en;
      end
      osr_pkg::OSR_CTRL_OFS:
      begin
        rd_word[osr_pkg::OSR_CTRL_CNT_BIT] = cnt_en;
      end
      osr_pkg::OSR_COUNT_OFS:
      begin
        rd_word[osr_pkg::OSR_CNT_W-1:0] = shift_cnt;
      end
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wb_dat_o <= '0;
    end
    else if (wb_req)
    begin
      wb_dat_o <= rd_word;
    end
  end

  // Control: soft clear pulse and counter enable
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      soft_clr <= 1'b0;
    end
    else
    begin
      soft_clr <= wr_fire & wb_sel_i[0]
        & (wb_adr_i == osr_pkg::OSR_CTRL_OFS)
        & wb_dat_i[osr_pkg::OSR_CTRL_CLR_BIT];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_en <= osr_pkg::OSR_CNT_EN_RST;
    end
    else if (wr_fire && wb_sel_i[0] && wb_adr_i == osr_pkg::OSR_CTRL_OFS)
    begin
      cnt_en <= wb_dat_i[osr_pkg::OSR_CTRL_CNT_BIT];
    end
  end

  // Counts shift and sign edges; a write clears it
  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_cnt <= osr_pkg::OSR_CNT_RST;
    end
    else if (wr_fire && wb_adr_i == osr_pkg::OSR_COUNT_OFS)
    begin
      shift_cnt <= osr_pkg::OSR_CNT_RST;
    end
    else if (cnt_en && stage_rst_n && !soft_clr && mode[1])
    begin
      shift_cnt <= shift_cnt + osr_pkg::OSR_CNT_ONE;
    end
  end

  chk_hold_keeps: assert property (
    @(posedge core_clk_i) disable iff (!stage_rst_n)
    (mode == osr_pkg::OSR_HOLD && !soft_clr) |=> $stable(stages))
    else $error("Stages changed in hold mode");

  chk_load_capture: assert property (
    @(posedge core_clk_i) disable iff (!stage_rst_n)
    (mode == osr_pkg::OSR_LOAD && !soft_clr) |=> stages == $past(par_in))
    else $error("Parallel load did not capture bus");

  chk_shift_down: assert property (
    @(posedge core_clk_i) disable iff (!stage_rst_n)
    (mode[1] && !soft_clr)
    |=> stages[WIDTH-2:0] == $past(stages[WIDTH-1:1]))
    else $error("Lower stages did not shift right");

  chk_entry_select: assert property (
    @(posedge core_clk_i) disable iff (!stage_rst_n)
    (mode == osr_pkg::OSR_SHIFT && !soft_clr)
    |=> stages[WIDTH-1] == $past(pins.entry_sel ? pins.entry_b
      : pins.entry_a))
    else $error("Top stage took wrong serial input");

  chk_sign_keep: assert property (
    @(posedge core_clk_i) disable iff (!stage_rst_n)
    (mode == osr_pkg::OSR_SIGN && !soft_clr) |=> $stable(stages[WIDTH-1]))
    else $error("Top stage lost its sign bit");

  chk_drive_off: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (pins.out_en_n || (!pins.shift_sel && stage_rst_n))
    |-> par_bus_oe_o == '0)
    else $error("Bus driven while disabled or loading");

  chk_clear_drive: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (!stage_rst_n && !pins.out_en_n) |-> par_bus_oe_o == '1)
    else $error("Bus not driven with zeros during clear");

  chk_drive_on: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    (!pins.out_en_n && pins.shift_sel)
    |-> (par_bus_oe_o == '1 && par_bus_o == stages))
    else $error("Bus not driven from stages");

  chk_clear_zero: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    !stage_rst_n |-> (stages == '0 && !ser_out_o))
    else $error("Clear did not empty the register");

  chk_clear_release: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    $rose(stage_rst_n) |-> stages == '0)
    else $error("Register not zero after clear release");

  chk_wb_ack_pulse: assert property (
    @(posedge core_clk_i) disable iff (!rst_n)
    wb_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("Bus ack not a single cycle");

endmodule
`default_nettype wire

/* logic/osr_stage.sv */
`timescale 1ns/1ps
`default_nettype none
module osr_stage (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sync_clr_i,
  input wire osr_pkg::osr_mode_t mode_i,
  input wire logic par_i,
  input wire logic upper_i,
  output logic q_o
);

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q_o <= osr_pkg::OSR_STAGE_RST;
    end
    else if (sync_clr_i)
    begin
      q_o <= osr_pkg::OSR_STAGE_RST;
    end
    else
    begin
      case (mode_i)
        osr_pkg::OSR_LOAD: q_o <= par_i;
        osr_pkg::OSR_SHIFT: q_o <= upper_i;
        osr_pkg::OSR_SIGN: q_o <= upper_i;
        default: q_o <= q_o;
      endcase
    end
  end

endmodule
`default_nettype wire

/* logic/osr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module osr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;
  logic [W-1:0] mid;
  logic [W-1:0] late;

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= RST_VAL;
      mid <= RST_VAL;
      late <= RST_VAL;
    end
    else
    begin
      meta <= d_i;
      mid <= meta;
      late <= mid;
    end
  end

  // A bit moves only once the two later stages agree
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q_o <= RST_VAL;
    end
    else
    begin
      q_o <= (mid & late) | (q_o & (mid | late));
    end
  end

endmodule
`default_nettype wire

/* tb/osr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module osr_host_model (
  input wire logic core_clk_i,
  input wire osr_pkg::osr_pins_t pins_i,
  input wire logic [7:0] host_dat_i,
  input wire logic host_drv_i,
  input wire logic [7:0] dev_dat_i,
  input wire logic [7:0] dev_oe_i,
  output osr_pkg::osr_pins_t pins_o,
  output logic [7:0] bus_o
);
  logic [7:0] last = 8'h00;

  // Pins change only just after an edge, then stand
  assign pins_o = pins_i;

  // Undriven wire shows the inverse of its last driven level
  assign bus_o = (dev_oe_i & dev_dat_i) |
    (~dev_oe_i & (host_drv_i ? host_dat_i : ~last));

  always_ff @(posedge core_clk_i)
  begin
    if ((|dev_oe_i) || host_drv_i)
    begin
      last <= bus_o;
    end
  end
endmodule
`default_nettype wire

/* tb/test_osr_shift_reg.sv */
`timescale 1ns/1ps
`default_nettype none
module test_osr_shift_reg;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clr_n = 1'b1;
  osr_pkg::osr_pins_t p = osr_pkg::OSR_PINS_RST;
  osr_pkg::osr_pins_t hp;
  logic [7:0] host = 8'h00;
  logic drv = 1'b0;
  logic [7:0] bus;
  logic [7:0] q;
  logic [7:0] oe;
  logic so;
  logic ack;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic [7:0] ex = 8'h00;
  logic [15:0] s = 16'h233D;
  int fail_count = 0;
  int cmp_count = 0;
  int cnt = 0;

  always #12.5 clk = ~clk;

  osr_host_model host_m (.core_clk_i(clk), .pins_i(p),
    .host_dat_i(host), .host_drv_i(drv), .dev_dat_i(q),
    .dev_oe_i(oe), .pins_o(hp), .bus_o(bus));

  osr_shift_reg uut (.core_clk_i(clk), .reset_n_i(rst_n),
    .clear_n_i(clr_n), .shift_load_gate_n_i(hp.gate_n),
    .shift_sel_i(hp.shift_sel), .top_bit_keep_n_i(hp.keep_n),
    .entry_sel_i(hp.entry_sel), .entry_bit_a_i(hp.entry_a),
    .entry_bit_b_i(hp.entry_b), .out_en_n_i(hp.out_en_n),
    .par_bus_i(bus), .par_bus_o(q), .par_bus_oe_o(oe), .ser_out_o(so),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  function automatic logic [7:0] nxt(input logic [7:0] v,
    input logic k, input logic es, input logic a, input logic b);
    return {k ? (es ? b : a) : v[7], v[7:1]};
  endfunction

  task automatic chk(input string n, input logic [31:0] got,
    input logic [31:0] exp);
    begin
      cmp_count++;
      if (got !== exp)
      begin
        fail_count++;
        $display("[ERR] %s expected %h seen %h", n, exp, got);
      end
    end
  endtask

  task automatic conclude;
    begin
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] r);
    int i;
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      i = 0;
      do
      begin
        @(posedge clk);
        i++;
      end
      while (ack !== 1'b1 && i < 50);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (i >= 50)
      begin
        fail_count++;
        conclude();
      end
    end
  endtask

  // Set mode with gate high, open gate for n edges, then check
  task automatic op(input logic sel, input logic k, input logic es,
    input logic a, input logic b, input logic oen,
    input logic [7:0] d, input int n);
    begin
      host <= d;
      drv <= !sel;
      p <= {1'b1, sel, k, es, a, b, oen};
      repeat (6) @(posedge clk);
      if (n > 0)
        p.gate_n <= 1'b0;
      repeat (n) @(posedge clk);
      p.gate_n <= 1'b1;
      repeat (6) @(posedge clk);
      for (int i = 0; i < n; i++)
        ex = sel ? nxt(ex, k, es, a, b) : d;
      if (sel)
        cnt += n;
      chk("stages", q, ex);
      chk("serial", so, ex[0]);
      chk("drive", oe, (sel && !oen) ? 8'hFF : 8'h00);
    end
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset", q, 8'h00);
    wb(1'b1, osr_pkg::OSR_COUNT_OFS, 32'h0, rd);
    op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h80, 2);
    op(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 3);
    op(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 8'h00, 5);
    for (int j = 0; j < 16; j++)
    begin
      s = lfsr(s);
      op(s[0] | s[1], s[2], s[3], s[4], s[5], s[6], s[15:8],
        s[9] ? 0 : 2 + s[8:7]);
    end
    wb(1'b0, osr_pkg::OSR_COUNT_OFS, 32'h0, rd);
    chk("count", rd, cnt);
    wb(1'b0, osr_pkg::OSR_STATUS_OFS, 32'h0, rd);
    chk("status", rd[7:0], ex);
    op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h5A, 2);
    clr_n <= 1'b0;
    #1;
    chk("clr stages", q, 8'h00);
    chk("clr serial", so, 1'b0);
    chk("clr drive off", oe, 8'h00);
    @(posedge clk);
    clr_n <= 1'b1;
    ex = 8'h00;
    op(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 0);
    op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h3C, 0);
    clr_n <= 1'b0;
    #1;
    chk("clr drive on", oe, 8'hFF);
    chk("clr zeros", q, 8'h00);
    @(posedge clk);
    clr_n <= 1'b1;
    op(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h3C, 2);
    wb(1'b1, osr_pkg::OSR_CTRL_OFS, 32'h3, rd);
    repeat (2) @(posedge clk);
    chk("soft clear", q, 8'h00);
    wb(1'b0, osr_pkg::OSR_CTRL_OFS, 32'h0, rd);
    chk("ctrl", rd, 32'h2);
    wb(1'b0, 4'hC, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
